// file: pkg/cabbs_pkg.sv
// Shared constants for the bit and branch ALU subset: register map,
// instruction word layout, flag positions, opcodes and core states.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package cabbs_pkg;

    // ==================================================================
    // Register map, byte offsets.
    localparam logic [11:0] OFS_INSTR     = 12'h000;
    localparam logic [11:0] OFS_ACCUM     = 12'h004;
    localparam logic [11:0] OFS_FLAGS     = 12'h008;
    localparam logic [11:0] OFS_IPTR      = 12'h00C;
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam logic [11:0] OFS_FILE_BASE = 12'h200;

    // ==================================================================
    // Instruction word layout.
    localparam int OP_LSB     = 0;
    localparam int OP_W       = 4;
    localparam int DEST_POS   = 4;
    localparam int FADDR_LSB  = 5;
    localparam int FADDR_W    = 7;
    localparam int BITSEL_LSB = 12;
    localparam int BITSEL_W   = 3;
    localparam int OFFS_LSB   = 16;
    localparam int OFFS_W     = 9;

    // ==================================================================
    // Flag and status bit positions.
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_HALF  = 1;
    localparam int FLAG_ZERO  = 2;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_SKIP  = 1;

    // ==================================================================
    // Values after reset and sizes.
    localparam logic [7:0] ACCUM_RST  = 8'h00;
    localparam int         FILE_DEPTH = 128;

    // ==================================================================
    // Opcodes and core states.
    typedef enum logic [3:0] {
        OP_AND_ACCUM_INTO_FILE          = 4'h0,
        OP_ADD_ACCUM_FILE               = 4'h1,
        OP_ARITH_SHIFT_RIGHT_FILE       = 4'h2,
        OP_ADD_ACCUM_FILE_WITH_OVERFLOW = 4'h3,
        OP_BIT_CLEAR_FILE               = 4'h4,
        OP_TEST_SKIP_IF_LOW             = 4'h5,
        OP_RELATIVE_JUMP                = 4'h6,
        OP_NOP                          = 4'hF
    } cabbs_opcode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_NOP  = 2'b11
    } cabbs_state_t;

endpackage

// file: rtl/cabbs_core.sv
// ALU and branch core for a subset of an 8-bit instruction set, behind
// an AHB-Lite slave. Assumes a single master issuing single word transfers.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module cabbs_core #(
    parameter int IPTR_W = 15
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);

    // ==================================================================
    // Declarations.
    cabbs_pkg::cabbs_state_t  stateQ;
    cabbs_pkg::cabbs_opcode_t op;
    logic              dpValidQ, dpWriteQ, dpFileQ, rdPendQ;
    logic [9:0]        dpAddrQ;
    logic [31:0]       instrQ, regRdata, flagsV;
    logic [7:0]        accumQ, memRdata, memWdata, result;
    logic [6:0]        memWaddr, memRaddr, faddr;
    logic [2:0]        bitSel;
    logic [8:0]        offs, sum9;
    logic [4:0]        half5;
    logic [IPTR_W-1:0] iptrQ, offsExt;
    logic carryQ, halfQ, zeroQ, skipQ, destF, cin, memWe;
    logic accept, fileA, wrDone, start, idle, busy, arith, skipTaken;

    assign accept = hsel && htrans[1] && hready;
    assign fileA  = haddr[11:9] == cabbs_pkg::OFS_FILE_BASE[11:9];
    assign wrDone = dpValidQ && dpWriteQ && hreadyout;
    assign idle   = stateQ == cabbs_pkg::ST_IDLE;
    assign start  = wrDone && !dpFileQ
                    && {dpAddrQ, 2'b00} == cabbs_pkg::OFS_INSTR;
    assign busy   = !idle || start;

    // ==================================================================
    // Instruction fields.
    assign op      = cabbs_pkg::cabbs_opcode_t'(
                     instrQ[cabbs_pkg::OP_LSB +: cabbs_pkg::OP_W]);
    assign destF   = instrQ[cabbs_pkg::DEST_POS];
    assign faddr   = instrQ[cabbs_pkg::FADDR_LSB +: cabbs_pkg::FADDR_W];
    assign bitSel  = instrQ[cabbs_pkg::BITSEL_LSB +: cabbs_pkg::BITSEL_W];
    assign offs    = instrQ[cabbs_pkg::OFFS_LSB +: cabbs_pkg::OFFS_W];
    assign offsExt = {{(IPTR_W-9){offs[8]}}, offs};

    // ==================================================================
    // Datapath.
    always_comb begin
        arith = op inside {cabbs_pkg::OP_AND_ACCUM_INTO_FILE,
                           cabbs_pkg::OP_ADD_ACCUM_FILE,
                           cabbs_pkg::OP_ARITH_SHIFT_RIGHT_FILE,
                           cabbs_pkg::OP_ADD_ACCUM_FILE_WITH_OVERFLOW};
        cin = (op == cabbs_pkg::OP_ADD_ACCUM_FILE_WITH_OVERFLOW) && carryQ;
        sum9  = {1'b0, accumQ} + {1'b0, memRdata} + {8'h00, cin};
        half5 = {1'b0, accumQ[3:0]} + {1'b0, memRdata[3:0]} + {4'h0, cin};
        skipTaken = (op == cabbs_pkg::OP_TEST_SKIP_IF_LOW)
                    && !memRdata[bitSel];
        case (op)
            cabbs_pkg::OP_AND_ACCUM_INTO_FILE: begin
                result = accumQ & memRdata;
            end
            cabbs_pkg::OP_ADD_ACCUM_FILE,
            cabbs_pkg::OP_ADD_ACCUM_FILE_WITH_OVERFLOW: begin
                result = sum9[7:0];
            end
            cabbs_pkg::OP_ARITH_SHIFT_RIGHT_FILE: begin
                result = {memRdata[7], memRdata[7:1]};
            end
            cabbs_pkg::OP_BIT_CLEAR_FILE: begin
                result = memRdata & ~(8'h01 << bitSel);
            end
            default: begin
                result = memRdata;
            end
        endcase
    end

    // ==================================================================
    // File register store. Bus access is held off while the core runs,
    // so the two users never meet on a port.
    assign memWe    = (stateQ == cabbs_pkg::ST_EXEC
                      && ((arith && destF)
                          || op == cabbs_pkg::OP_BIT_CLEAR_FILE))
                      || (wrDone && dpFileQ);
    assign memWaddr = (stateQ == cabbs_pkg::ST_EXEC) ? faddr : dpAddrQ[6:0];
    assign memWdata = (stateQ == cabbs_pkg::ST_EXEC) ? result : hwdata[7:0];
    assign memRaddr = start
                      ? hwdata[cabbs_pkg::FADDR_LSB +: cabbs_pkg::FADDR_W]
                      : dpAddrQ[6:0];

    cabbs_file_mem #(
        .DEPTH (cabbs_pkg::FILE_DEPTH),
        .AW    (7),
        .DW    (8)
    ) fileMem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wrEn    (memWe),
        .wrAddr  (memWaddr),
        .wrData  (memWdata),
        .rdAddr  (memRaddr),
        .rdDataQ (memRdata)
    );

    // ==================================================================
    // Sequencer.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stateQ <= cabbs_pkg::ST_IDLE;
        end else begin
            case (stateQ)
                cabbs_pkg::ST_IDLE: begin
                    if (start) begin
                        stateQ <= skipQ ? cabbs_pkg::ST_NOP
                                        : cabbs_pkg::ST_EXEC;
                    end
                end
                cabbs_pkg::ST_EXEC: begin
                    if (op == cabbs_pkg::OP_RELATIVE_JUMP || skipTaken) begin
                        stateQ <= cabbs_pkg::ST_NOP;
                    end else begin
                        stateQ <= cabbs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    stateQ <= cabbs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            skipQ <= 1'b0;
        end else if (stateQ == cabbs_pkg::ST_EXEC && skipTaken) begin
            skipQ <= 1'b1;
        end else if (start && skipQ) begin
            skipQ <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iptrQ <= '0;
        end else if (wrDone && {dpAddrQ, 2'b00} == cabbs_pkg::OFS_IPTR) begin
            iptrQ <= hwdata[IPTR_W-1:0];
        end else if (start && skipQ) begin
            iptrQ <= iptrQ + IPTR_W'(1);
        end else if (stateQ == cabbs_pkg::ST_EXEC) begin
            if (op == cabbs_pkg::OP_RELATIVE_JUMP) begin
                iptrQ <= iptrQ + IPTR_W'(1) + offsExt;
            end else begin
                iptrQ <= iptrQ + IPTR_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            instrQ <= '0;
        end else if (start) begin
            instrQ <= hwdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accumQ <= cabbs_pkg::ACCUM_RST;
        end else if (wrDone && !dpFileQ
                     && {dpAddrQ, 2'b00} == cabbs_pkg::OFS_ACCUM) begin
            accumQ <= hwdata[7:0];
        end else if (stateQ == cabbs_pkg::ST_EXEC && arith && !destF) begin
            accumQ <= result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            {zeroQ, halfQ, carryQ} <= 3'h0;
        end else if (wrDone && !dpFileQ
                     && {dpAddrQ, 2'b00} == cabbs_pkg::OFS_FLAGS) begin
            carryQ <= hwdata[cabbs_pkg::FLAG_CARRY];
            halfQ  <= hwdata[cabbs_pkg::FLAG_HALF];
            zeroQ  <= hwdata[cabbs_pkg::FLAG_ZERO];
        end else if (stateQ == cabbs_pkg::ST_EXEC && arith) begin
            zeroQ <= result == 8'h00;
            if (op == cabbs_pkg::OP_ARITH_SHIFT_RIGHT_FILE) begin
                carryQ <= memRdata[0];
            end else if (op != cabbs_pkg::OP_AND_ACCUM_INTO_FILE) begin
                carryQ <= sum9[8];
                halfQ  <= half5[4];
            end
        end
    end

    // ==================================================================
    // Bus slave. Register reads answer with no wait state; file access,
    // and writes while the core runs, wait until the core is idle.
    always_comb begin
        flagsV = '0;
        flagsV[cabbs_pkg::FLAG_CARRY] = carryQ;
        flagsV[cabbs_pkg::FLAG_HALF]  = halfQ;
        flagsV[cabbs_pkg::FLAG_ZERO]  = zeroQ;
        case ({haddr[11:2], 2'b00})
            cabbs_pkg::OFS_INSTR:  regRdata = instrQ;
            cabbs_pkg::OFS_ACCUM:  regRdata = 32'(accumQ);
            cabbs_pkg::OFS_FLAGS:  regRdata = flagsV;
            cabbs_pkg::OFS_IPTR:   regRdata = 32'(iptrQ);
            cabbs_pkg::OFS_STATUS: begin
                regRdata = 32'h0000_0000;
                regRdata[cabbs_pkg::STAT_BUSY] = busy;
                regRdata[cabbs_pkg::STAT_SKIP] = skipQ;
            end
            default: regRdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dpValidQ  <= 1'b0;
            dpWriteQ  <= 1'b0;
            dpFileQ   <= 1'b0;
            dpAddrQ   <= '0;
            rdPendQ   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
        end else begin
            rdPendQ <= 1'b0;
            if (accept) begin
                dpValidQ  <= 1'b1;
                dpWriteQ  <= hwrite;
                dpFileQ   <= fileA;
                dpAddrQ   <= haddr[11:2];
                hreadyout <= !(fileA || (hwrite && busy));
                if (!hwrite) begin
                    hrdata <= fileA ? 32'h0000_0000 : regRdata;
                end
            end else if (dpValidQ && hreadyout) begin
                dpValidQ <= 1'b0;
            end else if (dpValidQ) begin
                if (rdPendQ) begin
                    hrdata    <= 32'(memRdata);
                    hreadyout <= 1'b1;
                end else if (idle && dpFileQ && !dpWriteQ) begin
                    rdPendQ <= 1'b1;
                end else if (idle) begin
                    hreadyout <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        hresp <= 1'b0;
    end

    // ==================================================================
    // Checks.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence execOf(cabbs_pkg::cabbs_opcode_t o);
        stateQ == cabbs_pkg::ST_EXEC && op == o;
    endsequence

    sequence skipEntry;
        execOf(cabbs_pkg::OP_TEST_SKIP_IF_LOW) ##0 !memRdata[bitSel];
    endsequence

    and_result_a: assert property (
        execOf(cabbs_pkg::OP_AND_ACCUM_INTO_FILE) ##0 !destF |=>
        accumQ == $past(accumQ & memRdata) && $stable({carryQ, halfQ})
        && zeroQ == (accumQ == 8'h00))
        else $error("AND result or flags wrong.");

    add_sum_a: assert property (
        execOf(cabbs_pkg::OP_ADD_ACCUM_FILE) ##0 !destF |=>
        {carryQ, accumQ} == $past({1'b0, accumQ} + {1'b0, memRdata}))
        else $error("Add result or carry wrong.");

    asr_shift_a: assert property (
        execOf(cabbs_pkg::OP_ARITH_SHIFT_RIGHT_FILE) ##0 destF |->
        memWe && memWdata == {memRdata[7], memRdata[7:1]}
        ##1 carryQ == $past(memRdata[0]))
        else $error("Shift result or carry wrong.");

    addc_sum_a: assert property (
        execOf(cabbs_pkg::OP_ADD_ACCUM_FILE_WITH_OVERFLOW) ##0 !destF |=>
        {carryQ, accumQ} == $past({1'b0, accumQ} + {1'b0, memRdata}
                                  + {8'h00, carryQ}))
        else $error("Add with carry wrong.");

    bit_clear_a: assert property (
        execOf(cabbs_pkg::OP_BIT_CLEAR_FILE) |->
        memWe && !memWdata[bitSel]
        && (memWdata | (8'h01 << bitSel)) == (memRdata | (8'h01 << bitSel))
        ##1 $stable({carryQ, halfQ, zeroQ}))
        else $error("Bit clear wrong.");

    skip_taken_a: assert property (
        skipEntry |=> stateQ == cabbs_pkg::ST_NOP
        ##1 stateQ == cabbs_pkg::ST_IDLE && skipQ)
        else $error("Skip not taken in two cycles.");

    jump_target_a: assert property (
        execOf(cabbs_pkg::OP_RELATIVE_JUMP) |=>
        stateQ == cabbs_pkg::ST_NOP
        && iptrQ == $past(iptrQ) + IPTR_W'(1) + $past(offsExt)
        && $stable({carryQ, halfQ, zeroQ}))
        else $error("Relative jump target wrong.");

    // The operand is fetched from the bus word before it is latched, so
    // check the fetched byte against the store at the latched address.
    file_addr_a: assert property (
        stateQ == cabbs_pkg::ST_EXEC |->
        memRdata == fileMem.mem[faddr]
        && (!memWe || memWaddr == faddr))
        else $error("File operand address wrong.");

    nop_quiet_a: assert property (
        stateQ == cabbs_pkg::ST_NOP |-> !memWe
        ##1 $stable(accumQ) && $stable({carryQ, halfQ, zeroQ}))
        else $error("Second cycle not idle.");

    half_zero_a: assert property (
        execOf(cabbs_pkg::OP_ADD_ACCUM_FILE) ##0 !destF |=>
        halfQ == ($past(accumQ[3:0]) + $past(memRdata[3:0]) > 5'd15)
        && zeroQ == (accumQ == 8'h00))
        else $error("Half carry or zero wrong.");

endmodule

// file: rtl/cabbs_file_mem.sv
// File register store: one write port, one read port, registered read.
// Assumes the caller never writes and reads conflicting data in one cycle.
`timescale 1ns/1ps
module cabbs_file_mem #(
    parameter int DEPTH = 128,
    parameter int AW    = 7,
    parameter int DW    = 8
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Write port
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    // Read port
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdDataQ
);

    // ==================================================================
    // Storage. Contents are left unreset, as a real register file would.
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdDataQ <= '0;
        end else begin
            rdDataQ <= mem[rdAddr];
        end
    end

endmodule

// file: sim/tb.sv
// Self-checking bench for the ALU core: an AHB-Lite master drives the
// register port and a bench model of the instruction subset predicts.
// Assumes the core is the only slave, so its hreadyout is the bus hready.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb;
    // ==================================================================
    // Signals and model state.
    logic        sys_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = 32'h0000_0000;
    logic [1:0]  htrans      = 2'b00;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'b010;
    logic [31:0] hwdata      = 32'h0000_0000;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [31:0] rdVal;
    int          fail_count  = 0;
    int          check_count = 0;
    int          waitA;
    int          waitB;
    integer      seed        = 55967;
    logic [31:0] rnd;
    logic [7:0]  mAcc        = 8'h00;
    logic [2:0]  mFlg        = 3'b000;
    logic [14:0] mIp         = 15'h0000;
    logic        mSkip       = 1'b0;
    logic [7:0]  mFile [128];

    always #5 sys_clk = ~sys_clk;

    cabbs_core u_cabbs_core (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata)
    );

    // ==================================================================
    // Bus cycles. The wait count of the data phase is returned because
    // the extra cycle of a jump or a taken skip only shows as a stall.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd, output int waits);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge sys_clk);
        end
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waits = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && waits < 50) begin
            waits++;
            @(posedge sys_clk);
        end
        rdVal = hrdata;
        `CHK("hready", 1'b1, hreadyout)
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, waitA);
    endtask

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0000_0000, waitA);
    endtask

    function automatic logic [11:0] fileAddr(input logic [6:0] n);
        return cabbs_pkg::OFS_FILE_BASE + {3'b000, n, 2'b00};
    endfunction

    function automatic logic [31:0] mk(input logic [3:0] op, input logic d,
        input logic [6:0] fa, input logic [2:0] b, input logic [8:0] off);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[3:0] = op;
        v[4] = d;
        v[11:5] = fa;
        v[14:12] = b;
        v[24:16] = off;
        return v;
    endfunction

    // ==================================================================
    // Model of one instruction; a discarded one only moves the pointer.
    task automatic model_exec(input logic [31:0] ins);
        logic [6:0] fa;
        logic [7:0] f;
        logic [7:0] r;
        logic [8:0] s;
        logic [4:0] h;
        logic       c;
        logic       upd;
        fa = ins[11:5];
        f = mFile[fa];
        upd = 1'b0;
        mIp = mIp + 15'd1;
        if (mSkip) begin
            mSkip = 1'b0;
            return;
        end
        case (ins[3:0])
            4'h0: begin
                r = mAcc & f;
                upd = 1'b1;
                mFlg[2] = (r == 8'h00);
            end
            4'h1, 4'h3: begin
                c = (ins[3:0] == 4'h3) ? mFlg[0] : 1'b0;
                s = {1'b0, mAcc} + {1'b0, f} + {8'h00, c};
                h = {1'b0, mAcc[3:0]} + {1'b0, f[3:0]} + {4'h0, c};
                r = s[7:0];
                upd = 1'b1;
                mFlg = {r == 8'h00, h[4], s[8]};
            end
            4'h2: begin
                r = {f[7], f[7:1]};
                upd = 1'b1;
                mFlg[0] = f[0];
                mFlg[2] = (r == 8'h00);
            end
            4'h4: mFile[fa][ins[14:12]] = 1'b0;
            4'h5: mSkip = ~f[ins[14:12]];
            4'h6: mIp = mIp + {{6{ins[24]}}, ins[24:16]};
            default: ;
        endcase
        if (upd && ins[4]) begin
            mFile[fa] = r;
        end else if (upd) begin
            mAcc = r;
        end
    endtask

    task automatic check_state(input logic [6:0] fa);
        rd(cabbs_pkg::OFS_ACCUM);
        `CHK("accum", mAcc, rdVal[7:0])
        rd(cabbs_pkg::OFS_FLAGS);
        `CHK("flags", mFlg, rdVal[2:0])
        rd(cabbs_pkg::OFS_IPTR);
        `CHK("iptr", mIp, rdVal[14:0])
        rd(fileAddr(fa));
        `CHK("file", mFile[fa], rdVal[7:0])
        rd(cabbs_pkg::OFS_STATUS);
        `CHK("skip", mSkip, rdVal[cabbs_pkg::STAT_SKIP])
    endtask

    task automatic exec(input logic [31:0] ins);
        int n;
        wr(cabbs_pkg::OFS_INSTR, ins);
        n = 0;
        rd(cabbs_pkg::OFS_STATUS);
        while (rdVal[cabbs_pkg::STAT_BUSY] !== 1'b0 && n < 20) begin
            n++;
            rd(cabbs_pkg::OFS_STATUS);
        end
        `CHK("busy", 1'b0, rdVal[cabbs_pkg::STAT_BUSY])
        model_exec(ins);
        check_state(ins[11:5]);
    endtask

    // Loads operands and pointer, then runs one instruction.
    task automatic corner(input logic [7:0] a, input logic [2:0] fl,
        input logic [14:0] ip, input logic [7:0] fv, input logic [31:0] ins);
        wr(cabbs_pkg::OFS_ACCUM, {24'h00_0000, a});
        wr(cabbs_pkg::OFS_FLAGS, {29'h0000_0000, fl});
        wr(cabbs_pkg::OFS_IPTR, {17'h0_0000, ip});
        wr(fileAddr(ins[11:5]), {24'h00_0000, fv});
        mAcc = a;
        mFlg = fl;
        mIp = ip;
        mFile[ins[11:5]] = fv;
        exec(ins);
    endtask

    // A flags write straight after the instruction stalls until it ends.
    task automatic timed(input logic [31:0] ins, output int w);
        wr(cabbs_pkg::OFS_INSTR, ins);
        xfer(1'b1, cabbs_pkg::OFS_FLAGS, 32'h0000_0000, w);
        model_exec(ins);
        mFlg = 3'b000;
        check_state(ins[11:5]);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==================================================================
    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 128; i++) begin
            rnd = $random(seed);
            mFile[i] = rnd[7:0];
            wr(fileAddr(7'(i)), {24'h00_0000, rnd[7:0]});
        end
        // Reset values are checked only once every file word is known.
        check_state(7'd0);
        corner(8'hFF, 3'b000, 15'h0000, 8'h01, mk(4'h1, 0, 0, 0, 0));
        corner(8'h0F, 3'b000, 15'h0001, 8'h01, mk(4'h1, 1, 127, 0, 0));
        corner(8'h7F, 3'b001, 15'h0002, 8'h80, mk(4'h3, 0, 5, 0, 0));
        corner(8'h7F, 3'b000, 15'h0003, 8'h80, mk(4'h3, 1, 5, 0, 0));
        corner(8'h0F, 3'b011, 15'h0004, 8'hF0, mk(4'h0, 0, 9, 0, 0));
        corner(8'h3C, 3'b111, 15'h0005, 8'hF3, mk(4'h0, 1, 9, 0, 0));
        corner(8'hAA, 3'b000, 15'h0006, 8'h81, mk(4'h2, 1, 3, 0, 0));
        corner(8'hAA, 3'b010, 15'h0007, 8'h01, mk(4'h2, 0, 3, 0, 0));
        corner(8'h55, 3'b111, 15'h0008, 8'hFF, mk(4'h4, 1, 4, 7, 0));
        corner(8'h55, 3'b111, 15'h0009, 8'h01, mk(4'h4, 0, 4, 0, 0));
        corner(8'h10, 3'b111, 15'h0010, 8'hFE, mk(4'h5, 0, 6, 0, 0));
        exec(mk(4'h1, 0, 6, 0, 0));
        corner(8'h10, 3'b101, 15'h0020, 8'h80, mk(4'h5, 0, 6, 7, 0));
        exec(mk(4'h1, 0, 6, 0, 0));
        corner(8'h00, 3'b111, 15'h0010, 8'h00, mk(4'h6, 0, 1, 0, 9'h100));
        corner(8'h00, 3'b010, 15'h7FFF, 8'h00, mk(4'h6, 0, 1, 0, 9'h0FF));
        corner(8'h00, 3'b000, 15'h0100, 8'h00, mk(4'h6, 0, 1, 0, 9'h1FF));
        timed(mk(4'hF, 0, 2, 0, 0), waitB);
        timed(mk(4'h6, 0, 2, 0, 9'h003), waitA);
        `CHK("jump stall", waitB + 1, waitA)
        wr(fileAddr(7'd6), 32'h0000_0001);
        mFile[6] = 8'h01;
        timed(mk(4'h5, 0, 6, 0, 0), waitB);
        timed(mk(4'h5, 0, 6, 1, 0), waitA);
        `CHK("skip stall", waitB + 1, waitA)
        exec(mk(4'h2, 0, 6, 0, 0));
        repeat (300) begin
            rnd = $random(seed);
            exec(mk((rnd[2:0] == 3'd7) ? 4'hF : {1'b0, rnd[2:0]}, rnd[3],
                    rnd[10:4], rnd[13:11], rnd[22:14]));
        end
        rd(12'h100);
        `CHK("unmapped", 32'h0000_0000, rdVal)
        wr(12'h014, 32'hFFFF_FFFF);
        rd(12'h014);
        `CHK("unmapped", 32'h0000_0000, rdVal)
        wrap_up();
    end

    // The full run needs some 6000 cycles; this allows a wide margin.
    initial begin
        #300_000;
        fail_count++;
        wrap_up();
    end
endmodule
